// ---- capture_assertions.sv ----
`timescale 1ns/10ps
`default_nettype none
// ****************
// Link and sequence checker
// ****************
module capture_assertions #(
	parameter int READ_LEN = 32
) (
	input wire logic MCLK,
	input wire logic SRST,
	input wire logic exposure_request_in,
	input wire logic frame_request_in,
	input wire logic EXPOSING,
	input wire logic SAMPLING,
	input wire logic READING,
	input wire logic FRAME_DONE
);
	logic [15:0] rd_cnt_q;
	logic [15:0] rd_cnt_d;
	// Cycles spent in the current readout
	always_comb begin
		rd_cnt_d = READING ? rd_cnt_q + 16'h0001 : 16'h0000;
	end
	always_ff @(posedge MCLK) begin
		rd_cnt_q <= SRST ? 16'h0000 : rd_cnt_d;
	end
	default clocking cb @(posedge MCLK); endclocking
	default disable iff (SRST);
	// Request pins and state outputs
	chk_exp_starts_exposure: assert property ($rose(exposure_request_in) && !SAMPLING |-> ##[1:6] EXPOSING)
		else $error("exposure did not start");
	chk_frame_starts_sample: assert property ($rose(frame_request_in) && EXPOSING |-> ##[1:6] SAMPLING)
		else $error("sampling did not start");
	chk_sample_min_len: assert property ($rose(SAMPLING) |-> SAMPLING[*4])
		else $error("sampling too short");
	chk_read_follows_sample: assert property ($fell(SAMPLING) |-> READING)
		else $error("readout did not follow sampling");
	chk_sample_alone: assert property (SAMPLING |-> !READING && !EXPOSING)
		else $error("sampling overlaps another state");
	chk_read_full_len: assert property ($fell(READING) && !SAMPLING |-> rd_cnt_q == 16'(READ_LEN))
		else $error("readout length wrong");
	chk_done_one_cycle: assert property (FRAME_DONE |=> !FRAME_DONE)
		else $error("frame done too long");
	chk_exp_pulse_width: assert property ($rose(exposure_request_in) |-> exposure_request_in[*3] ##1 !exposure_request_in)
		else $error("exposure pulse width wrong");
	chk_frame_pulse_width: assert property ($rose(frame_request_in) |-> frame_request_in[*3] ##1 !frame_request_in)
		else $error("frame pulse width wrong");
	// Main scenarios
	cov_abort: cover property ($fell(READING) && SAMPLING);
	cov_sample: cover property ($rose(SAMPLING));
	cov_done: cover property (FRAME_DONE);
endmodule
`default_nettype wire

// ---- capture_controller.sv ----
`timescale 1ns/10ps
`default_nettype none
module capture_controller
	import capture_pkg::*;
(
	input wire logic MCLK,
	input wire logic SRST,
	capture_if.controller LINK,
	input wire logic EXP_START,
	input wire logic FRAME_START,
	output logic BUSY,
	output logic REFUSED
);
	typedef enum logic [1:0] {C_IDLE, C_EXP, C_FRM} ctl_t;

	// ****************************************
	// Pulse generator for the two request pins
	// ****************************************
	ctl_t st_q, st_d;
	logic [7:0] cnt_q, cnt_d;
	logic exposed_q, exposed_d, busy_d, ref_d, expo_d, frmo_d;
	always_comb begin
		st_d = st_q;
		cnt_d = (cnt_q != 8'h00) ? cnt_q - 8'h01 : cnt_q;
		exposed_d = exposed_q;
		ref_d = 1'b0;
		unique case (st_q)
			C_IDLE: begin
				if (EXP_START) begin
					st_d = C_EXP;
					cnt_d = 8'(REQ_PULSE_CYC);
					exposed_d = 1'b1;
				end else if (FRAME_START) begin
					if (exposed_q) begin
						st_d = C_FRM;
						cnt_d = 8'(REQ_PULSE_CYC);
						exposed_d = 1'b0;
					end else begin
						ref_d = 1'b1;
					end
				end
			end
			C_EXP, C_FRM: begin
				if (cnt_q <= 8'h01) begin
					st_d = C_IDLE;
				end
			end
			default: st_d = C_IDLE;
		endcase
		busy_d = st_d != C_IDLE;
		expo_d = st_d == C_EXP;
		frmo_d = st_d == C_FRM;
	end
	always_ff @(posedge MCLK) begin
		if (SRST) begin
			st_q <= C_IDLE;
			cnt_q <= 8'h00;
			exposed_q <= 1'b0;
			BUSY <= 1'b0;
			REFUSED <= 1'b0;
			LINK.exposure_request_in <= 1'b0;
			LINK.frame_request_in <= 1'b0;
		end else begin
			st_q <= st_d;
			cnt_q <= cnt_d;
			exposed_q <= exposed_d;
			BUSY <= busy_d;
			REFUSED <= ref_d;
			LINK.exposure_request_in <= expo_d;
			LINK.frame_request_in <= frmo_d;
		end
	end
endmodule
`default_nettype wire

// ---- capture_if.sv ----
`timescale 1ns/10ps
`default_nettype none
// Request pins between frame controller and sensor
interface capture_if;
	logic exposure_request_in;
	logic frame_request_in;
	modport sensor (input exposure_request_in, input frame_request_in);
	modport controller (output exposure_request_in, output frame_request_in);
endinterface
`default_nettype wire

// ---- capture_pkg.sv ----
package capture_pkg;
	// Register map
	localparam logic [7:0] MODE_ADDR = 8'h09;
	localparam logic [7:0] EXPTIME_ADDR = 8'h0A;
	localparam logic [7:0] GLOBLEN_ADDR = 8'h0B;
	localparam logic [7:0] READLEN_ADDR = 8'h0C;
	localparam logic [7:0] FRAMETIME_ADDR = 8'h0D;
	localparam logic [7:0] NFRAMES_ADDR = 8'h0E;
	localparam logic [7:0] STATUS_ADDR = 8'h0F;
	localparam int MODE_W = 3;
	localparam int CNT_W = 16;
	localparam logic [MODE_W-1:0] MODE_RST = 3'h0;
	localparam logic [MODE_W-1:0] MODE_FULL_EXT = 3'h0;
	localparam logic [MODE_W-1:0] MODE_PROG_EXT = 3'h1;
	localparam logic [MODE_W-1:0] MODE_TRIG_INT = 3'h2;
	localparam logic [MODE_W-1:0] MODE_STREAM = 3'h3;
	localparam logic [CNT_W-1:0] EXPTIME_RST = 16'h0010;
	localparam logic [CNT_W-1:0] GLOBLEN_RST = 16'h0004;
	localparam logic [CNT_W-1:0] READLEN_RST = 16'h0020;
	localparam logic [CNT_W-1:0] FRAMETIME_RST = 16'h0040;
	localparam logic [7:0] NFRAMES_RST = 8'h01;
	// Least request pulse width at the controller, in ns and cycles
	localparam int CLK_PERIOD_NS = 100;
	localparam int REQ_PULSE_NS = 300;
	localparam int REQ_PULSE_CYC = (REQ_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
endpackage

// ---- capture_sensor.sv ----
`timescale 1ns/10ps
`default_nettype none
module capture_sensor
	import capture_pkg::*;
(
	input wire logic MCLK,
	input wire logic SRST,
	capture_if.sensor LINK,
	input wire logic REG_WE,
	input wire logic [7:0] REG_ADDR,
	input wire logic [15:0] REG_WDATA,
	output logic [15:0] REG_RDATA,
	output logic EXPOSING,
	output logic SAMPLING,
	output logic READING,
	output logic FRAME_CORRUPT,
	output logic FRAME_DONE
);
	typedef enum logic [1:0] {IDLE, GLOBAL_SAMPLE_STATE_S, READOUT} main_t;

	// ****************************************
	// Request synchronisers
	// ****************************************
	logic [2:0] exp_sync_q, exp_sync_d, frm_sync_q, frm_sync_d;
	logic exp_pulse, frm_pulse;
	always_comb begin
		exp_sync_d = {exp_sync_q[1:0], LINK.exposure_request_in};
		frm_sync_d = {frm_sync_q[1:0], LINK.frame_request_in};
	end
	always_ff @(posedge MCLK) begin
		if (SRST) begin
			exp_sync_q <= 3'h0;
			frm_sync_q <= 3'h0;
		end else begin
			exp_sync_q <= exp_sync_d;
			frm_sync_q <= frm_sync_d;
		end
	end
	// Edge detect on second and third stages only
	assign exp_pulse = exp_sync_q[1] & ~exp_sync_q[2];
	assign frm_pulse = frm_sync_q[1] & ~frm_sync_q[2];

	// ****************************************
	// Registers
	// ****************************************
	logic [MODE_W-1:0] mode_q, mode_d;
	logic [CNT_W-1:0] exptime_q, exptime_d, globlen_q, globlen_d;
	logic [CNT_W-1:0] readlen_q, readlen_d, ftime_q, ftime_d;
	logic [7:0] nframes_q, nframes_d;
	logic [15:0] rdata_d;
	always_comb begin
		mode_d = mode_q;
		exptime_d = exptime_q;
		globlen_d = globlen_q;
		readlen_d = readlen_q;
		ftime_d = ftime_q;
		nframes_d = nframes_q;
		if (REG_WE) begin
			unique case (REG_ADDR)
				MODE_ADDR: mode_d = REG_WDATA[MODE_W-1:0];
				EXPTIME_ADDR: exptime_d = REG_WDATA;
				GLOBLEN_ADDR: globlen_d = REG_WDATA;
				READLEN_ADDR: readlen_d = REG_WDATA;
				FRAMETIME_ADDR: ftime_d = REG_WDATA;
				NFRAMES_ADDR: nframes_d = REG_WDATA[7:0];
				default: ;
			endcase
		end
	end
	always_ff @(posedge MCLK) begin
		if (SRST) begin
			mode_q <= MODE_RST;
			exptime_q <= EXPTIME_RST;
			globlen_q <= GLOBLEN_RST;
			readlen_q <= READLEN_RST;
			ftime_q <= FRAMETIME_RST;
			nframes_q <= NFRAMES_RST;
		end else begin
			mode_q <= mode_d;
			exptime_q <= exptime_d;
			globlen_q <= globlen_d;
			readlen_q <= readlen_d;
			ftime_q <= ftime_d;
			nframes_q <= nframes_d;
		end
	end

	// ****************************************
	// Sequencer
	// ****************************************
	main_t st_q, st_d;
	logic exp_on_q, exp_on_d; // Exposure runs beside readout in the two external modes
	logic [CNT_W-1:0] ecnt_q, ecnt_d, scnt_q, scnt_d, fcnt_q, fcnt_d;
	logic [CNT_W-1:0] lat_exp_q, lat_exp_d, lat_ft_q, lat_ft_d;
	logic [7:0] left_q, left_d;
	logic bad_q, bad_d, done_d;
	logic internal, timed, exp_end, start_global_sample_state, corrupt_global_sample_state;
	always_comb begin
		internal = (mode_q == MODE_TRIG_INT) || (mode_q == MODE_STREAM);
		timed = mode_q != MODE_FULL_EXT;
		st_d = st_q;
		exp_on_d = exp_on_q;
		ecnt_d = ecnt_q;
		scnt_d = (scnt_q != '0) ? scnt_q - 16'h0001 : scnt_q;
		fcnt_d = (fcnt_q != '0) ? fcnt_q - 16'h0001 : fcnt_q;
		lat_exp_d = lat_exp_q;
		lat_ft_d = lat_ft_q;
		left_d = left_q;
		bad_d = bad_q;
		done_d = 1'b0;
		start_global_sample_state = 1'b0;
		corrupt_global_sample_state = 1'b0;
		// Programmed timer expiry ends the exposure
		exp_end = timed && exp_on_q && (ecnt_q <= 16'h0001);
		if (exp_on_q && timed && !exp_end) begin
			ecnt_d = ecnt_q - 16'h0001;
		end
		// Exposure request: latch timing, start or restart exposure
		if (exp_pulse && !(internal && (exp_on_q || st_q != IDLE))) begin
			lat_exp_d = exptime_q;
			lat_ft_d = ftime_q;
			ecnt_d = exptime_q;
			exp_on_d = 1'b1;
			if (internal) begin
				left_d = (mode_q == MODE_TRIG_INT) ? nframes_q : 8'h00;
				fcnt_d = '0;
			end
			if (st_q == GLOBAL_SAMPLE_STATE_S) begin
				bad_d = 1'b1;
			end
			exp_end = 1'b0;
		end else if (exp_pulse && mode_q == MODE_TRIG_INT && left_q != 8'hFF) begin
			left_d = left_q + 8'h01; // Extend sequence
		end
		// Internal modes wait for the frame time before ending exposure
		if (internal && exp_end && fcnt_q != '0) begin
			exp_end = 1'b0;
			ecnt_d = 16'h0001;
		end
		if (mode_q == MODE_FULL_EXT && frm_pulse) begin
			start_global_sample_state = 1'b1;
			corrupt_global_sample_state = !exp_on_q || st_q == GLOBAL_SAMPLE_STATE_S;
			exp_on_d = 1'b0;
		end else if (exp_end && !(exp_pulse && exp_on_d && ecnt_d == exptime_q && !internal)) begin
			start_global_sample_state = 1'b1;
			corrupt_global_sample_state = st_q == GLOBAL_SAMPLE_STATE_S;
			exp_on_d = 1'b0;
		end
		unique case (st_q)
			IDLE: ;
			GLOBAL_SAMPLE_STATE_S: begin
				if (scnt_q <= 16'h0001) begin
					st_d = READOUT;
					scnt_d = readlen_q;
				end
			end
			READOUT: begin
				if (scnt_q <= 16'h0001) begin
					done_d = 1'b1;
					bad_d = 1'b0;
					st_d = IDLE;
					if (internal && (mode_q == MODE_STREAM || left_q > 8'h01)) begin
						if (mode_q == MODE_TRIG_INT) begin
							left_d = left_q - 8'h01;
						end
						exp_on_d = 1'b1; // Next frame of the run
						ecnt_d = lat_exp_q;
					end
				end
			end
			default: st_d = IDLE;
		endcase
		if (start_global_sample_state) begin
			st_d = GLOBAL_SAMPLE_STATE_S;
			scnt_d = globlen_q;
			fcnt_d = lat_ft_q;
			bad_d = corrupt_global_sample_state || (exp_pulse && st_q == GLOBAL_SAMPLE_STATE_S);
			if (st_q == READOUT && !corrupt_global_sample_state) begin
				bad_d = 1'b0;
			end
		end
	end
	always_ff @(posedge MCLK) begin
		if (SRST) begin
			st_q <= IDLE;
			exp_on_q <= 1'b0;
			ecnt_q <= '0;
			scnt_q <= '0;
			fcnt_q <= '0;
			lat_exp_q <= EXPTIME_RST;
			lat_ft_q <= FRAMETIME_RST;
			left_q <= 8'h00;
			bad_q <= 1'b0;
			FRAME_DONE <= 1'b0;
		end else begin
			st_q <= st_d;
			exp_on_q <= exp_on_d;
			ecnt_q <= ecnt_d;
			scnt_q <= scnt_d;
			fcnt_q <= fcnt_d;
			lat_exp_q <= lat_exp_d;
			lat_ft_q <= lat_ft_d;
			left_q <= left_d;
			bad_q <= bad_d;
			FRAME_DONE <= done_d;
		end
	end

	// ****************************************
	// Status outputs and read data
	// ****************************************
	always_comb begin
		unique case (REG_ADDR)
			MODE_ADDR: rdata_d = {13'h0000, mode_d};
			EXPTIME_ADDR: rdata_d = exptime_d;
			GLOBLEN_ADDR: rdata_d = globlen_d;
			READLEN_ADDR: rdata_d = readlen_d;
			FRAMETIME_ADDR: rdata_d = ftime_d;
			NFRAMES_ADDR: rdata_d = {8'h00, nframes_d};
			STATUS_ADDR: rdata_d = {12'h000, bad_d, st_d == READOUT, st_d == GLOBAL_SAMPLE_STATE_S, exp_on_d};
			default: rdata_d = 16'h0000;
		endcase
	end
	always_ff @(posedge MCLK) begin
		if (SRST) begin
			REG_RDATA <= 16'h0000;
			EXPOSING <= 1'b0;
			SAMPLING <= 1'b0;
			READING <= 1'b0;
			FRAME_CORRUPT <= 1'b0;
		end else begin
			REG_RDATA <= rdata_d;
			EXPOSING <= exp_on_d;
			SAMPLING <= st_d == GLOBAL_SAMPLE_STATE_S;
			READING <= st_d == READOUT;
			FRAME_CORRUPT <= bad_d;
		end
	end
endmodule
`default_nettype wire

// ---- tb_top.sv ----
`timescale 1ns/10ps
`default_nettype none
// ****************
// Controller to sensor bench
// ****************
module tb_top;
	import capture_pkg::*;
	logic MCLK, SRST, REG_WE, EXP_START, FRAME_START, e_p, f_p;
	logic [7:0] REG_ADDR;
	logic [15:0] REG_WDATA, REG_RDATA;
	logic EXPOSING, SAMPLING, READING, FRAME_CORRUPT, FRAME_DONE, BUSY, REFUSED;
	int err_total, cmp_count, cyc, exp_n, exp_last, t_e, t_f, ref_n;
	int crp_n, busy_n, done_n, done_base;
	capture_if ifc();
	capture_sensor i_capture_sensor(.MCLK(MCLK), .SRST(SRST), .LINK(ifc), .REG_WE(REG_WE),
		.REG_ADDR(REG_ADDR), .REG_WDATA(REG_WDATA), .REG_RDATA(REG_RDATA), .EXPOSING(EXPOSING),
		.SAMPLING(SAMPLING), .READING(READING), .FRAME_CORRUPT(FRAME_CORRUPT),
		.FRAME_DONE(FRAME_DONE));
	capture_controller i_capture_controller(.MCLK(MCLK), .SRST(SRST), .LINK(ifc),
		.EXP_START(EXP_START), .FRAME_START(FRAME_START), .BUSY(BUSY), .REFUSED(REFUSED));
	capture_assertions #(.READ_LEN(32)) i_capture_assertions(.MCLK(MCLK), .SRST(SRST),
		.exposure_request_in(ifc.exposure_request_in), .frame_request_in(ifc.frame_request_in),
		.EXPOSING(EXPOSING), .SAMPLING(SAMPLING), .READING(READING), .FRAME_DONE(FRAME_DONE));
	// Clock
	initial begin
		MCLK = 1'b0;
		forever #50 MCLK = ~MCLK;
	end
	// Pin edge times, exposure length, refusals and hang guard
	always @(posedge MCLK) begin
		cyc <= cyc + 1;
		e_p <= ifc.exposure_request_in;
		f_p <= ifc.frame_request_in;
		if (ifc.exposure_request_in === 1'b1 && e_p !== 1'b1) t_e <= cyc;
		if (ifc.frame_request_in === 1'b1 && f_p !== 1'b1) t_f <= cyc;
		if (EXPOSING === 1'b1) exp_n <= exp_n + 1;
		else if (exp_n != 0) begin
			exp_last <= exp_n;
			exp_n <= 0;
		end
		if (REFUSED === 1'b1) ref_n <= ref_n + 1;
		// Corrupt flag must never rise in the legal scenarios
		if (!SRST && FRAME_CORRUPT !== 1'b0) crp_n <= crp_n + 1;
		if (BUSY === 1'b1) busy_n <= busy_n + 1;
		if (FRAME_DONE === 1'b1) done_n <= done_n + 1;
		if (cyc > 6000) begin
			err_total++;
			stop_test();
		end
	end
	task cmp(input logic [15:0] got, input logic [15:0] exp);
		cmp_count++;
		if (got !== exp) begin
			err_total++;
			$display("CHECK FAILED %0t got %h want %h", $time, got, exp);
		end
	endtask
	task wr(input logic [7:0] a, input logic [15:0] d);
		@(posedge MCLK);
		REG_WE <= 1'b1;
		REG_ADDR <= a;
		REG_WDATA <= d;
		@(posedge MCLK);
		REG_WE <= 1'b0;
	endtask
	task rd(input logic [7:0] a, input logic [15:0] e);
		@(posedge MCLK);
		REG_ADDR <= a;
		repeat (2) @(posedge MCLK);
		#1 cmp(REG_RDATA, e);
	endtask
	// One request, then the pulse plus the least low gap
	task req(input logic frm);
		@(posedge MCLK);
		EXP_START <= !frm;
		FRAME_START <= frm;
		@(posedge MCLK);
		EXP_START <= 1'b0;
		FRAME_START <= 1'b0;
		repeat (REQ_PULSE_CYC * 2 + 2) @(posedge MCLK);
	endtask
	// Bounded wait: 0 frame done, 1 sampling, 2 reading
	task wait_for(input int sel);
		logic hit;
		hit = 1'b0;
		for (int i = 0; i < 400 && !hit; i++) begin
			@(posedge MCLK);
			#1;
			hit = (sel == 0) ? FRAME_DONE === 1'b1 : (sel == 1) ? SAMPLING === 1'b1 : READING === 1'b1;
		end
		// A wait that runs out counts as a mismatch
		if (!hit) begin
			err_total++;
			$display("CHECK FAILED %0t wait timed out", $time);
		end
	endtask
	task stop_test();
		$display("checks %0d mismatches %0d", cmp_count, err_total);
		if (err_total == 0 && cmp_count > 0) $display("ALL CHECKS OK");
		else $display("CHECKS NOT OK");
		$finish;
	endtask
	// Main sequence
	initial begin
		SRST = 1'b1;
		REG_WE = 1'b0;
		REG_ADDR = 8'h00;
		REG_WDATA = 16'h0000;
		EXP_START = 1'b0;
		FRAME_START = 1'b0;
		repeat (8) @(posedge MCLK);
		SRST <= 1'b0;
		rd(MODE_ADDR, 16'h0000);
		cmp({13'h0000, EXPOSING, SAMPLING, READING}, 16'h0000);
		for (int m = 3; m >= 0; m--) begin
			wr(MODE_ADDR, 16'(m));
			rd(MODE_ADDR, 16'(m));
		end
		$display("test registers done");
		req(1'b0);
		cmp(16'(busy_n), 16'(REQ_PULSE_CYC));
		repeat (12) @(posedge MCLK);
		req(1'b1);
		wait_for(0);
		cmp(16'(exp_last), 16'(t_f - t_e));
		cmp(16'(crp_n), 16'h0000);
		$display("test full external frame done");
		req(1'b0);
		req(1'b0);
		req(1'b1);
		wait_for(2);
		req(1'b0);
		req(1'b1);
		wait_for(0);
		cmp(16'(crp_n), 16'h0000);
		req(1'b1);
		cmp(16'(ref_n), 16'h0001);
		$display("test restart and abort done");
		wr(MODE_ADDR, 16'(MODE_PROG_EXT));
		wr(EXPTIME_ADDR, 16'h000C);
		req(1'b0);
		wr(EXPTIME_ADDR, 16'h0028);
		wait_for(0);
		cmp(16'(exp_last), 16'h000C);
		req(1'b1);
		repeat (10) @(posedge MCLK);
		cmp({14'h0000, SAMPLING, READING}, 16'h0000);
		$display("test programmed external done");
		// Triggered internal: one request yields a run of two frames
		wr(MODE_ADDR, 16'(MODE_TRIG_INT));
		wr(NFRAMES_ADDR, 16'h0002);
		done_base = done_n;
		req(1'b0);
		wait_for(0);
		wait_for(0);
		repeat (150) @(posedge MCLK);
		#1;
		cmp(16'(done_n - done_base), 16'h0002);
		cmp({13'h0000, EXPOSING, SAMPLING, READING}, 16'h0000);
		$display("test triggered internal done");
		stop_test();
	end
endmodule
`default_nettype wire
